/* adcc_pkg.sv */
// Shared types and constants of the converter control block.
// Assumes one synchronous clock domain; analog parts sit outside.
package adcc_pkg;
	localparam int          RES_W        = 16;
	localparam int          ACC_W        = 21;
	localparam logic [4:0]  CHAN_OFF     = 5'h1F;
	localparam logic [2:0]  SAMPLE_TICKS = 3'h4;
	localparam logic [15:0] DAC_MSB      = 16'h8000;
	localparam logic [15:0] DAC_LSB      = 16'h0001;
	localparam logic [1:0]  MODE_8       = 2'h0;
	localparam logic [1:0]  MODE_12      = 2'h1;
	localparam logic [1:0]  MODE_10      = 2'h2;
	localparam logic [1:0]  MODE_16      = 2'h3;
	localparam logic [4:0]  BITS_8       = 5'h08;
	localparam logic [4:0]  BITS_9       = 5'h09;
	localparam logic [4:0]  BITS_10      = 5'h0A;
	localparam logic [4:0]  BITS_11      = 5'h0B;
	localparam logic [4:0]  BITS_12      = 5'h0C;
	localparam logic [4:0]  BITS_13      = 5'h0D;
	localparam logic [4:0]  BITS_16      = 5'h10;
	localparam logic [2:0]  AVG_SH_MIN   = 3'h2;
	localparam logic [5:0]  AVG_CNT_MIN  = 6'h04;

	typedef struct packed {
		logic       int_en;
		logic       differential_select_bit;
		logic [4:0] chan;
	} adcc_ctrl_type;

	typedef struct packed {
		logic [1:0] mode;
		logic [1:0] clk_sel;
		logic       hw_trig;
		logic [1:0] trig_sel;
		logic       cont;
		logic       avg_en;
		logic [1:0] avg_sel;
		logic       cmp_en;
		logic       cmp_gt;
		logic       cmp_ren;
		logic       dma_en;
	} adcc_cfg_type;

	typedef struct packed {
		logic       differential_select_bit;
		logic [4:0] chan;
	} adcc_mux_type;

	typedef enum logic [2:0] {
		ST_IDLE = 3'h1,
		ST_RUN  = 3'h2,
		ST_END  = 3'h4
	} adcc_st_type;

	typedef enum logic [2:0] {
		SAR_IDLE = 3'h1,
		SAR_SAMP = 3'h2,
		SAR_CONV = 3'h4
	} adcc_sar_st_type;

	function automatic logic [4:0] adcc_res_bits(input logic [1:0] mode, input logic differential_select_bit);
		case (mode)
			MODE_8:  adcc_res_bits = differential_select_bit ? BITS_9 : BITS_8;
			MODE_12: adcc_res_bits = differential_select_bit ? BITS_13 : BITS_12;
			MODE_10: adcc_res_bits = differential_select_bit ? BITS_11 : BITS_10;
			default: adcc_res_bits = BITS_16;
		endcase
	endfunction : adcc_res_bits
endpackage : adcc_pkg

/* adcc_cmpr.sv */
// Compare function on a finished result against one or two values.
// Assumes signed operands when the result came from a differential input.
module adcc_cmpr (
	input  wire logic [adcc_pkg::RES_W-1:0] i_res,
	input  wire logic [adcc_pkg::RES_W-1:0] i_cv1,
	input  wire logic [adcc_pkg::RES_W-1:0] i_cv2,
	input  wire logic                       i_signed,
	input  wire logic                       i_gt,
	input  wire logic                       i_ren,
	output logic                            o_hit
);
	import adcc_pkg::*;

	function automatic logic lt(input logic [15:0] a, input logic [15:0] b, input logic sg);
		lt = sg ? ((a ^ DAC_MSB) < (b ^ DAC_MSB)) : (a < b);
	endfunction : lt

	logic lt1;
	logic gt2;
	logic ord;

	always_comb begin
		lt1 = lt(i_res, i_cv1, i_signed);
		gt2 = lt(i_cv2, i_res, i_signed);
		ord = !lt(i_cv2, i_cv1, i_signed);
		case ({i_gt, i_ren})
			2'h0: o_hit = lt1;
			2'h2: o_hit = !lt1;
			2'h1: o_hit = ord ? (lt1 || gt2) : (lt1 && gt2);
			2'h3: o_hit = ord ? (!lt1 && !gt2) : (!lt1 || !gt2);
			default: o_hit = 1'b0;
		endcase
	end
endmodule : adcc_cmpr

/* adcc_sar.sv */
// Successive approximation sequencer: sample phase, then one bit per tick.
// Assumes the external comparator output is settled at each tick.
module adcc_sar (
	input  wire logic                       i_ref_clk,
	input  wire logic                       i_resetn,
	input  wire logic                       i_start,
	input  wire logic                       i_abort,
	input  wire logic                       i_tick,
	input  wire logic [4:0]                 i_nbits,
	input  wire logic                       i_cmp,
	output logic      [adcc_pkg::RES_W-1:0] o_dac_code,
	output logic                            o_sample,
	output logic                            o_done,
	output logic      [adcc_pkg::RES_W-1:0] o_raw
);
	import adcc_pkg::*;

	typedef struct packed {
		adcc_sar_st_type st;
		logic [2:0]      cnt;
		logic [3:0]      bitp;
		logic [15:0]     code;
		logic [15:0]     dac;
		logic            sample;
		logic            done;
		logic [15:0]     raw;
	} adcc_sar_state_type;

	adcc_sar_state_type s_q;
	adcc_sar_state_type s_d;
	logic [3:0]         lsb;
	logic [15:0]        keep;

	always_comb begin
		s_d = s_q;
		s_d.done = 1'b0;
		lsb = 4'(BITS_16 - i_nbits);
		keep = i_cmp ? s_q.dac : s_q.code;
		if (i_start) begin
			s_d.st = SAR_SAMP;
			s_d.sample = 1'b1;
			s_d.cnt = 3'h0;
			s_d.dac = 16'h0000;
		end else if (i_abort) begin
			s_d.st = SAR_IDLE;
			s_d.sample = 1'b0;
			s_d.dac = 16'h0000;
		end else begin
			case (s_q.st)
				SAR_IDLE: s_d.st = SAR_IDLE;
				SAR_SAMP: if (i_tick) begin
					s_d.cnt = s_q.cnt + 3'h1;
					if (s_q.cnt == SAMPLE_TICKS - 3'h1) begin
						s_d.st = SAR_CONV;
						s_d.sample = 1'b0;
						s_d.code = 16'h0000;
						s_d.dac = DAC_MSB;
						s_d.bitp = 4'hF;
					end
				end
				SAR_CONV: if (i_tick) begin
					s_d.code = keep;
					// Stopping at the mode's LSB gives the selected resolution
					if (s_q.bitp == lsb) begin
						s_d.st = SAR_IDLE;
						s_d.done = 1'b1;
						s_d.raw = keep >> lsb;
						s_d.dac = 16'h0000;
					end else begin
						s_d.bitp = s_q.bitp - 4'h1;
						s_d.dac = keep | (DAC_LSB << (s_q.bitp - 4'h1));
					end
				end
				default: s_d.st = SAR_IDLE;
			endcase
		end
	end

	always_ff @(posedge i_ref_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			s_q <= '{st: SAR_IDLE, default: '0};
		end else begin
			s_q <= s_d;
		end
	end

	assign o_dac_code = s_q.dac;
	assign o_sample   = s_q.sample;
	assign o_done     = s_q.done;
	assign o_raw      = s_q.raw;

	a_raw_width: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
		o_done |-> ((o_raw >> i_nbits) == 16'h0000))
		else $error("raw result wider than resolution");
endmodule : adcc_sar

/* adcc_top.sv */
// Conversion control of a successive approximation converter.
// Assumes all inputs synchronous to i_ref_clk; analog mux, DAC and comparator outside.
module adcc_top (
	input  wire logic                       i_ref_clk,
	input  wire logic                       i_resetn,
	input  wire adcc_pkg::adcc_ctrl_type    i_ctrl_a,
	input  wire logic                       i_ctrl_a_wr,
	input  wire adcc_pkg::adcc_ctrl_type    i_ctrl_b,
	input  wire logic                       i_ctrl_b_wr,
	input  wire adcc_pkg::adcc_cfg_type     i_cfg,
	input  wire logic [adcc_pkg::RES_W-1:0] i_cv1,
	input  wire logic [adcc_pkg::RES_W-1:0] i_cv2,
	input  wire logic [3:0]                 i_trig_src,
	input  wire logic                       i_trig_ab,
	input  wire logic [3:0]                 i_clk_tick,
	input  wire logic                       i_sar_cmp,
	input  wire logic [1:0]                 i_rd_result,
	output logic      [adcc_pkg::RES_W-1:0] o_dac_code,
	output logic                            o_sample,
	output adcc_pkg::adcc_mux_type          o_mux,
	output logic      [adcc_pkg::RES_W-1:0] o_result_a,
	output logic      [adcc_pkg::RES_W-1:0] o_result_b,
	output logic      [1:0]                 o_conversion_complete_flag,
	output logic                            o_irq,
	output logic                            o_dma_req,
	output logic                            o_busy,
	output logic                            o_active
);
	import adcc_pkg::*;

	typedef struct packed {
		adcc_st_type                 st;
		adcc_ctrl_type [1:0]         regs;
		logic                        act;
		adcc_mux_type                mux;
		logic                        start;
		logic                        abort;
		logic [ACC_W-1:0]            acc;
		logic [5:0]                  acnt;
		logic [15:0]                 fmt;
		logic [1:0][15:0]            res;
		logic [1:0]                  conversion_complete_flag;
		logic                        irq;
		logic                        dma;
		logic                        busy;
	} adcc_top_state_type;

	adcc_top_state_type s_q;
	adcc_top_state_type s_d;

	// Differential pairs only exist on channels 0..3
	function automatic adcc_mux_type mux_of(input adcc_ctrl_type c);
		mux_of.differential_select_bit = c.differential_select_bit;
		mux_of.chan = c.differential_select_bit ? {3'h0, c.chan[1:0]} : c.chan;
	endfunction : mux_of

	function automatic logic [15:0] fmt_result(
		input logic [15:0] raw,
		input logic [4:0]  nb,
		input logic        differential_select_bit
	);
		logic [15:0] top_bit;
		logic [15:0] x;
		top_bit = DAC_LSB << (nb - 5'h01);
		x = raw ^ top_bit;
		if (!differential_select_bit) begin
			fmt_result = raw;
		end else if ((x & top_bit) != 16'h0000) begin
			fmt_result = x | (~16'h0000 << nb);
		end else begin
			fmt_result = x;
		end
	endfunction : fmt_result

	function automatic logic [ACC_W-1:0] ext(input logic [15:0] v, input logic differential_select_bit);
		ext = differential_select_bit ? {{5{v[15]}}, v} : {5'h00, v};
	endfunction : ext

	logic             tick;
	logic             hw_ev;
	logic             go_sw;
	logic             go_hw;
	logic [4:0]       nbits;
	logic [15:0]      raw;
	logic             sar_done;
	logic [15:0]      f;
	logic [ACC_W-1:0] sum;
	logic [5:0]       cnt_tgt;
	logic [2:0]       sh;
	logic             cmp_raw;
	logic             hit;
	adcc_ctrl_type    hw_c;

	assign tick    = i_clk_tick[i_cfg.clk_sel];
	assign hw_ev   = i_cfg.hw_trig && i_trig_src[i_cfg.trig_sel];
	assign nbits   = adcc_res_bits(i_cfg.mode, s_q.mux.differential_select_bit);
	assign cnt_tgt = AVG_CNT_MIN << i_cfg.avg_sel;
	assign sh      = AVG_SH_MIN + {1'b0, i_cfg.avg_sel};

	adcc_sar u_sar (
		.i_ref_clk  (i_ref_clk),
		.i_resetn   (i_resetn),
		.i_start    (s_q.start),
		.i_abort    (s_q.abort),
		.i_tick     (tick),
		.i_nbits    (nbits),
		.i_cmp      (i_sar_cmp),
		.o_dac_code (o_dac_code),
		.o_sample   (o_sample),
		.o_done     (sar_done),
		.o_raw      (raw)
	);

	adcc_cmpr u_cmpr (
		.i_res    (s_q.fmt),
		.i_cv1    (i_cv1),
		.i_cv2    (i_cv2),
		.i_signed (s_q.mux.differential_select_bit),
		.i_gt     (i_cfg.cmp_gt),
		.i_ren    (i_cfg.cmp_ren),
		.o_hit    (cmp_raw)
	);

	// A failed compare drops the result and leaves the flag untouched
	assign hit = !i_cfg.cmp_en || cmp_raw;

	always_comb begin
		s_d = s_q;
		s_d.start = 1'b0;
		s_d.abort = 1'b0;
		s_d.dma = 1'b0;
		f = fmt_result(raw, nbits, s_q.mux.differential_select_bit);
		sum = s_q.acc + ext(f, s_q.mux.differential_select_bit);
		// Writing a register restarts its flag; reads clear flags too
		if (i_ctrl_a_wr) begin
			s_d.regs[0] = i_ctrl_a;
			s_d.conversion_complete_flag[0] = 1'b0;
		end
		if (i_ctrl_b_wr) begin
			s_d.regs[1] = i_ctrl_b;
			s_d.conversion_complete_flag[1] = 1'b0;
		end
		for (int i = 0; i < 2; i++) begin
			if (i_rd_result[i]) begin
				s_d.conversion_complete_flag[i] = 1'b0;
			end
		end
		hw_c = s_d.regs[i_trig_ab];
		go_sw = !i_cfg.hw_trig && i_ctrl_a_wr && (i_ctrl_a.chan != CHAN_OFF);
		go_hw = hw_ev && (s_q.st == ST_IDLE) && (hw_c.chan != CHAN_OFF);
		case (s_q.st)
			ST_IDLE: s_d.st = ST_IDLE;
			ST_RUN: if (sar_done) begin
				if (i_cfg.avg_en) begin
					s_d.acc = sum;
					s_d.acnt = s_q.acnt + 6'h01;
					if (s_q.acnt + 6'h01 >= cnt_tgt) begin
						s_d.fmt = s_q.mux.differential_select_bit ? 16'($signed(sum) >>> sh) : 16'(sum >> sh);
						s_d.st = ST_END;
					end else begin
						s_d.start = 1'b1;
					end
				end else begin
					s_d.fmt = f;
					s_d.st = ST_END;
				end
			end
			ST_END: begin
				if (hit) begin
					s_d.res[s_q.act] = s_q.fmt;
					s_d.conversion_complete_flag[s_q.act] = 1'b1;
					s_d.dma = i_cfg.dma_en;
				end
				s_d.acc = '0;
				s_d.acnt = 6'h00;
				if (i_cfg.cont) begin
					s_d.start = 1'b1;
					s_d.st = ST_RUN;
				end else begin
					s_d.st = ST_IDLE;
				end
			end
			default: s_d.st = ST_IDLE;
		endcase
		// Rewriting the register in control aborts its conversion
		// Placed after the case so an abort on the last step also drops a pending restart
		if (s_q.st != ST_IDLE && !go_sw) begin
			if ((i_ctrl_a_wr && !s_q.act) || (i_ctrl_b_wr && s_q.act)) begin
				s_d.abort = 1'b1;
				s_d.start = 1'b0;
				s_d.st = ST_IDLE;
			end
		end
		if (go_sw || go_hw) begin
			s_d.act = go_hw ? i_trig_ab : 1'b0;
			s_d.mux = mux_of(go_hw ? hw_c : i_ctrl_a);
			s_d.start = 1'b1;
			s_d.abort = 1'b0;
			s_d.acc = '0;
			s_d.acnt = 6'h00;
			s_d.st = ST_RUN;
		end
		s_d.irq = |(s_d.conversion_complete_flag & {s_d.regs[1].int_en, s_d.regs[0].int_en});
		s_d.busy = (s_d.st != ST_IDLE);
	end

	always_ff @(posedge i_ref_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			s_q <= '{st: ST_IDLE, regs: {2{7'h1F}}, default: '0};
		end else begin
			s_q <= s_d;
		end
	end

	assign o_mux      = s_q.mux;
	assign o_result_a = s_q.res[0];
	assign o_result_b = s_q.res[1];
	assign o_conversion_complete_flag     = s_q.conversion_complete_flag;
	assign o_irq      = s_q.irq;
	assign o_dma_req  = s_q.dma;
	assign o_busy     = s_q.busy;
	assign o_active   = s_q.act;

	a_flag_on_end: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
		(s_q.st == ST_END && hit && !s_q.act && !i_ctrl_a_wr) |=> o_conversion_complete_flag[0])
		else $error("completion flag not set");

	a_irq_cause: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
		o_irq |-> |o_conversion_complete_flag)
		else $error("interrupt without flag");

	a_single_idle: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
		(s_q.st == ST_END && !i_cfg.cont && !go_sw && !go_hw) |=> !o_busy)
		else $error("single conversion did not return to idle");

	a_dma_pulse: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
		(s_q.st == ST_END && hit && i_cfg.dma_en) |=> o_dma_req ##1 !o_dma_req)
		else $error("dma request missing or too long");

	a_dma_off: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
		!i_cfg.dma_en |=> !o_dma_req)
		else $error("dma request while disabled");

	a_sw_start_a: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
		(!i_cfg.hw_trig && i_ctrl_a_wr && i_ctrl_a.chan != CHAN_OFF) |=> (o_busy && !o_active))
		else $error("software write did not start conversion");

	a_b_soft_idle: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
		(!i_cfg.hw_trig && s_q.st == ST_IDLE && !i_ctrl_a_wr) |=> !o_busy)
		else $error("conversion started without trigger");

	a_hw_select: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
		go_hw |=> (o_active == $past(i_trig_ab)) && o_busy)
		else $error("hardware trigger chose wrong register");

	a_cmp_gate: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
		(s_q.st == ST_END && !hit) |=> ($stable(o_result_a) && $stable(o_result_b)))
		else $error("result stored despite failed compare");

	a_se_unsigned: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
		(s_q.st == ST_RUN && sar_done && !s_q.mux.differential_select_bit && i_cfg.mode == MODE_8
			&& !i_cfg.avg_en) |=> (s_q.fmt[15:8] == 8'h00))
		else $error("single-ended result not right-justified");

	a_avg_flag: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
		$rose(o_conversion_complete_flag[0]) |-> ($past(s_q.st) == ST_END))
		else $error("flag set outside result stage");

	a_abort_idle: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
		(s_q.st != ST_IDLE && !go_sw && i_ctrl_a_wr && !s_q.act)
			|=> !o_busy)
		else $error("rewrite of register in control did not abort");

	a_owner_hold: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
		(s_q.st != ST_IDLE && !go_sw) |=> ($stable(o_active) && $stable(o_mux)))
		else $error("control changed hands during a conversion");

	a_b_write_keeps: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
		(s_q.st == ST_RUN && !sar_done && !s_q.act && i_ctrl_b_wr && !i_ctrl_a_wr)
			|=> o_busy)
		else $error("write to idle register disturbed conversion");

	a_off_no_start: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
		(!i_cfg.hw_trig && s_q.st == ST_IDLE && i_ctrl_a_wr && i_ctrl_a.chan == CHAN_OFF)
			|=> !o_busy)
		else $error("channel off started a conversion");

	a_cont_restart: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
		(s_q.st == ST_END && i_cfg.cont && !i_ctrl_a_wr && !i_ctrl_b_wr) |=> o_busy)
		else $error("continuous mode stopped after a result");

	// The abort needs one cycle to reach the sequencer, so that cycle is exempt
	a_dac_idle: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
		(s_q.st == ST_IDLE && !s_q.abort) |-> (o_dac_code == 16'h0000 && !o_sample))
		else $error("converter still active while idle");

	a_start_sample: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
		s_q.start |=> o_sample)
		else $error("start did not close the sample switch");

	a_rd_clears: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
		(i_rd_result[0] && !(s_q.st == ST_END && hit && !s_q.act)) |=> !o_conversion_complete_flag[0])
		else $error("read did not clear completion flag");

	a_irq_gate: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
		(|(o_conversion_complete_flag & {s_q.regs[1].int_en, s_q.regs[0].int_en})) |-> o_irq)
		else $error("enabled flag without interrupt");

	a_dma_flag: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
		o_dma_req |-> (|o_conversion_complete_flag))
		else $error("dma request without completion flag");

	// Keyed to the done cycle, since the configuration may change at any time
	a_differential_select_bit_sign: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
		(s_q.st == ST_END && s_q.mux.differential_select_bit && $past(sar_done) && !$past(i_cfg.avg_en)
			&& $past(i_cfg.mode) == MODE_8) |-> (s_q.fmt[15:8] == {8{s_q.fmt[8]}}))
		else $error("differential result not sign-extended");
endmodule : adcc_top

/* adcc_analog_model.sv */
// Analog side model: track-and-hold input, comparator and four tick sources.
// Assumes the bench holds the input level steady during a conversion.
module adcc_analog_model (
	input  wire logic        i_ref_clk,
	input  wire logic        i_resetn,
	input  wire logic [15:0] i_vin,
	input  wire logic [15:0] i_dac_code,
	input  wire logic        i_sample,
	output logic             o_cmp,
	output logic      [3:0]  o_tick
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [15:0] held_q;
	logic [3:0]  cnt_q;
	// Source k ticks every k+1 cycles, so a wrong clock select shifts timing
	always_ff @(posedge i_ref_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			held_q <= 16'h0000;
			cnt_q  <= 4'h0;
		end else begin
			cnt_q <= (cnt_q == 4'hB) ? 4'h0 : cnt_q + 4'h1;
			if (i_sample)
				held_q <= i_vin;
		end
	end
	always_comb begin
		o_cmp = (held_q >= i_dac_code);
		for (int k = 0; k < 4; k++)
			o_tick[k] = ((cnt_q % (k + 1)) == 0);
	end
endmodule : adcc_analog_model

/* adcc_top_tb_top.sv */
// Self-checking bench of the converter control block.
// Assumes the analog model answers the comparator and the tick inputs.
module adcc_top_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	import adcc_pkg::*;
	logic          i_ref_clk, i_resetn, i_ctrl_a_wr, i_ctrl_b_wr, i_trig_ab, i_sar_cmp;
	adcc_ctrl_type i_ctrl_a, i_ctrl_b;
	adcc_cfg_type  i_cfg;
	logic [15:0]   i_cv1, i_cv2, vin, o_dac_code, o_result_a, o_result_b;
	logic [3:0]    i_trig_src, i_clk_tick;
	logic [1:0]    i_rd_result, o_conversion_complete_flag;
	adcc_mux_type  o_mux;
	logic          o_sample, o_irq, o_dma_req, o_busy, o_active, smp_prev;
	logic [31:0]   seed = 32'h62837465;
	logic [31:0]   r;
	logic [7:0]    c1, c2;
	int            error_cnt = 0, n_compared = 0, dma_n = 0, smp_n = 0;

	adcc_top adcc_top_inst (.i_ref_clk, .i_resetn, .i_ctrl_a, .i_ctrl_a_wr, .i_ctrl_b,
		.i_ctrl_b_wr, .i_cfg, .i_cv1, .i_cv2, .i_trig_src, .i_trig_ab, .i_clk_tick,
		.i_sar_cmp, .i_rd_result, .o_dac_code, .o_sample, .o_mux, .o_result_a,
		.o_result_b, .o_conversion_complete_flag, .o_irq, .o_dma_req, .o_busy, .o_active);
	adcc_analog_model adcc_analog_model_inst (.i_ref_clk, .i_resetn, .i_vin(vin),
		.i_dac_code(o_dac_code), .i_sample(o_sample), .o_cmp(i_sar_cmp),
		.o_tick(i_clk_tick));

	always #12.5 i_ref_clk = ~i_ref_clk;
	always @(negedge i_ref_clk) begin
		dma_n += (o_dma_req === 1'b1);
		smp_n += (o_sample === 1'b1 && smp_prev !== 1'b1);
		smp_prev = o_sample;
	end

	function automatic logic [31:0] rnd();
		seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
		return seed;
	endfunction : rnd

	function automatic logic [15:0] exp_res(input logic [15:0] v, input logic [1:0] m,
		input logic d);
		int          nb;
		logic [15:0] x;
		nb = (m == 2'h0) ? 8 : (m == 2'h1) ? 12 : (m == 2'h2) ? 10 : 16;
		if (d && nb != 16)
			nb++;
		x = v >> (16 - nb);
		if (d) begin
			x[nb-1] = ~x[nb-1];
			if (x[nb-1])
				x = x | ~((16'h0001 << nb) - 16'h0001);
		end
		return x;
	endfunction : exp_res

	function automatic logic exp_hit(input logic [7:0] v, a, b, input logic gt, rn);
		case ({gt, rn})
			2'h0: return v < a;
			2'h2: return v >= a;
			2'h1: return (a <= b) ? (v < a || v > b) : (v < a && v > b);
			default: return (a <= b) ? (v >= a && v <= b) : (v >= a || v <= b);
		endcase
	endfunction : exp_hit

	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			error_cnt++;
			$display("unexpected %s: expected %h seen %h", nm, exp, seen);
		end
	endtask : chk

	task automatic wr(input logic b, ie, d, input logic [4:0] ch);
		@(posedge i_ref_clk);
		if (b) begin
			i_ctrl_b    <= '{int_en: ie, differential_select_bit: d, chan: ch};
			i_ctrl_b_wr <= 1'b1;
		end else begin
			i_ctrl_a    <= '{int_en: ie, differential_select_bit: d, chan: ch};
			i_ctrl_a_wr <= 1'b1;
		end
		@(posedge i_ref_clk);
		i_ctrl_a_wr <= 1'b0;
		i_ctrl_b_wr <= 1'b0;
	endtask : wr

	// Bounded wait for idle (flag=0) or for the first flag (flag=1)
	task automatic wait_on(input logic flag);
		int i;
		i = 0;
		repeat (3) @(negedge i_ref_clk);
		while ((flag ? o_conversion_complete_flag[0] !== 1'b1 : o_busy !== 1'b0) && i < 5000) begin
			@(negedge i_ref_clk);
			i++;
		end
		// Let the negedge counters settle before anyone reads them
		#1;
		chk("wait bound", i < 5000, 1);
	endtask : wait_on

	task automatic trig(input int s, input logic ab);
		@(posedge i_ref_clk);
		i_trig_ab  <= ab;
		i_trig_src <= 4'h1 << s;
		@(posedge i_ref_clk);
		i_trig_src <= 4'h0;
	endtask : trig

	task automatic report_and_stop();
		$display("errors %0d compared %0d", error_cnt, n_compared);
		if (error_cnt == 0 && n_compared > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : report_and_stop

	initial begin
		#1500000;
		error_cnt++;
		report_and_stop();
	end

	initial begin
		{i_ref_clk, i_resetn, i_ctrl_a_wr, i_ctrl_b_wr, i_trig_ab} = '0;
		{i_ctrl_a, i_ctrl_b, i_cfg, i_cv1, i_cv2, vin, i_trig_src, i_rd_result} = '0;
		repeat (6) @(posedge i_ref_clk);
		chk("busy in reset", o_busy, 0);
		chk("flags in reset", o_conversion_complete_flag, 0);
		i_resetn <= 1'b1;
		// No calibration store here; clock and mode settings precede every start
		// Every resolution, both input kinds, random clock source and channel
		for (int i = 0; i < 16; i++) begin
			r = rnd();
			@(posedge i_ref_clk);
			i_cfg.mode    <= i[1:0];
			i_cfg.clk_sel <= r[3:2];
			i_cfg.dma_en  <= i[3];
			vin           <= r[31:16];
			dma_n = 0;
			wr(0, r[4], i[2], {3'h0, r[6:5]});
			@(negedge i_ref_clk);
			chk("mux", o_mux, {i[2], 3'h0, r[6:5]});
			wait_on(0);
			chk("result", o_result_a, exp_res(r[31:16], i[1:0], i[2]));
			chk("flag", o_conversion_complete_flag, 2'h1);
			chk("irq", o_irq, r[4]);
			chk("dma", dma_n, i[3]);
			@(posedge i_ref_clk);
			i_rd_result <= 2'h1;
			@(posedge i_ref_clk);
			i_rd_result <= 2'h0;
			@(negedge i_ref_clk);
			chk("flag read", o_conversion_complete_flag, 0);
		end
		// Compare modes: bit 3 puts result on value one, bit 2 swaps value order
		@(posedge i_ref_clk);
		i_cfg <= '{cmp_en: 1'b1, default: '0};
		for (int i = 0; i < 16; i++) begin
			r = rnd();
			c1 = {i[2], r[22:16]};
			c2 = ~c1;
			@(posedge i_ref_clk);
			i_cfg.cmp_gt  <= i[0];
			i_cfg.cmp_ren <= i[1];
			i_cv1 <= {8'h00, c1};
			i_cv2 <= {8'h00, c2};
			vin   <= {i[3] ? c1 : r[15:8], r[7:0]};
			wr(0, 0, 0, 5'h01);
			wait_on(0);
			chk("hit", o_conversion_complete_flag[0], exp_hit(i[3] ? c1 : r[15:8], c1, c2, i[0], i[1]));
		end
		// Averaging of 4 to 32 conversions; 32 is the preferred setting for calibration
		@(posedge i_ref_clk);
		i_cfg <= '{mode: MODE_16, avg_en: 1'b1, default: '0};
		for (int s = 0; s < 4; s++) begin
			r = rnd();
			@(posedge i_ref_clk);
			i_cfg.avg_sel <= s[1:0];
			vin           <= r[15:0];
			smp_n = 0;
			wr(0, 0, 0, 5'h00);
			wait_on(0);
			chk("avg result", o_result_a, r[15:0]);
			chk("avg samples", smp_n, 4 << s);
		end
		// Continuous mode keeps running until the channel is turned off
		@(posedge i_ref_clk);
		i_cfg <= '{cont: 1'b1, default: '0};
		wr(0, 0, 0, 5'h02);
		wait_on(1);
		chk("busy cont", o_busy, 1);
		wr(0, 0, 0, CHAN_OFF);
		wait_on(0);
		// Second register never starts under software trigger
		@(posedge i_ref_clk);
		i_cfg <= '0;
		wr(1, 0, 0, 5'h02);
		wr(0, 0, 0, CHAN_OFF);
		repeat (8) @(negedge i_ref_clk);
		chk("b no start", o_busy, 0);
		// Hardware trigger with ping-pong registers
		r = rnd();
		@(posedge i_ref_clk);
		i_cfg.hw_trig  <= 1'b1;
		i_cfg.trig_sel <= 2'h2;
		vin            <= r[15:0];
		wr(0, 0, 0, 5'h01);
		trig(2, 0);
		repeat (2) @(negedge i_ref_clk);
		chk("active a", {o_busy, o_active}, 2'h2);
		wr(1, 0, 0, 5'h03);
		wait_on(0);
		chk("hw result a", o_result_a, exp_res(r[15:0], 2'h0, 0));
		trig(1, 0);
		repeat (8) @(negedge i_ref_clk);
		chk("wrong source", o_busy, 0);
		@(posedge i_ref_clk);
		vin <= r[31:16];
		trig(2, 1);
		repeat (2) @(negedge i_ref_clk);
		chk("active b", {o_active, o_mux}, {1'b1, 6'h03});
		wait_on(0);
		chk("hw result b", o_result_b, exp_res(r[31:16], 2'h0, 0));
		chk("both flags", o_conversion_complete_flag, 2'h3);
		// Reset in mid-conversion drops everything, and a new start works right after it
		@(posedge i_ref_clk);
		i_cfg <= '0;
		wr(0, 0, 0, 5'h01);
		repeat (4) @(posedge i_ref_clk);
		i_resetn <= 1'b0;
		@(negedge i_ref_clk);
		chk("state in reset", {o_busy, o_sample, o_conversion_complete_flag, o_dac_code}, 0);
		chk("results in reset", {o_result_a, o_result_b}, 0);
		@(posedge i_ref_clk);
		i_resetn <= 1'b1;
		wr(0, 0, 0, 5'h01);
		wait_on(0);
		chk("result after reset", o_result_a, exp_res(vin, 2'h0, 0));
		report_and_stop();
	end
endmodule : adcc_top_tb_top
